// File: core/flash_ctl_map.svh
// register offsets, field positions, reset values and timing counts of the array controller
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH

`define OFS_CONTROL       4'h0
`define OFS_BOUNDARY      4'h1
`define OFS_STATUS        4'h2
`define OFS_ARRAY_ADDR    4'h3
`define OFS_ARRAY_DATA    4'h4

`define BIT_PROGRAM_SELECT 0
`define BIT_ERASE_SELECT   1
`define BIT_WHOLE_ARRAY    2
`define BIT_HIGH_VOLTAGE   3

`define BIT_ST_RECOVERY    0
`define BIT_ST_PROTECTED   1
`define BIT_ST_ROW_MIX     2
`define BIT_ST_ARMED       3
`define BIT_ST_STANDBY     4

`define RESET_CONTROL      4'h0
`define RESET_BOUNDARY     8'hFF
`define ERASED_BYTE        8'hFF

`define CLK_MHZ            10
`define READ_RECOVERY_NS   1000
`define READ_RECOVERY_CYC  ((`READ_RECOVERY_NS * `CLK_MHZ + 999) / 1000)

`define ARRAY_BASE         16'hE000
`define BOUNDARY_ADDR      16'hFF7E

`endif

// File: core/flash_ctl_pkg.sv
// types of the array controller
package flash_ctl_pkg;
  typedef enum logic [1:0] {
    OP_IDLE    = 2'b00,
    OP_ARMED   = 2'b01,
    OP_HIGH    = 2'b10,
    OP_RECOVER = 2'b11
  } op_state_e;

  typedef struct packed {
    logic [3:0]  control;
    logic [7:0]  boundary;
    op_state_e   op;
    logic        checked;
    logic [10:0] row;
    logic        row_mix;
    logic        refused;
    logic        standby;
    logic [4:0]  rcv_count;
    logic        waitreq;
    logic [31:0] rdata;
    logic [7:0]  mem_data;
    logic [7:0]  mem_wdata;
    logic [15:0] mem_addr;
    logic        mem_wr;
    logic        mem_erase;
    logic        mem_whole;
    logic        pump;
  } flash_state_s;
endpackage : flash_ctl_pkg

// File: core/flash_erase_program_protect.sv
// array controller: control bits, protect boundary, row capture and an 8 KB array
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctl_map.svh"

// Overview of operation
// RULE1 - whole erase: select bits, read boundary, write
// RULE2 - software times erase setup, hold, high voltage
// RULE3 - reads blocked one microsecond after high voltage
// RULE4 - whole erase refused unless boundary all ones
// RULE5 - program in aligned 32-byte rows only
// RULE6 - software programs only erased bytes
// RULE7 - program select captures following array writes
// RULE8 - program: read boundary, row write, wait, voltage
// RULE9 - software spaces byte writes 30 to 40 us
// RULE10 - software clears select, waits, clears voltage
// RULE11 - software keeps byte gaps under program time
// RULE12 - software limits cumulative row high voltage
// RULE13 - boundary read between select and voltage
// RULE14 - high voltage blocked in protected range
// RULE15 - zeros protect all, ones protect none
// RULE16 - boundary byte itself protected once set
// RULE17 - bypass voltage on pin opens protection
// RULE18 - boundary is array byte, erased when open
// RULE19 - start address is 11, boundary, six zeros
// RULE20 - monitor mode dummy write hits boundary byte
// RULE21 - wait or stop abandons operation to standby
// RULE22 - standby holds all array controls inactive
// RULE23 - erase and program select never both one
// RULE24 - high voltage only after armed sequence
// RULE25 - erased bits read one, programmed zero
// RULE26 - refused operation changes nothing, no error
// RULE27 - control bits kept, software measures waits
module flash_erase_program_protect (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output var  logic [31:0] AVS_READDATA,
  output var  logic        AVS_WAITREQUEST,
  input  wire logic        LOW_POWER_ENTRY,
  input  wire logic        PROTECTION_BYPASS_VOLTAGE,
  output var  logic        HIGH_VOLTAGE_ON,
  output var  logic        READ_READY
);
  import flash_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // array storage, one programmed byte per cycle
  logic [7:0]    array_mem [0:8191];
  logic [8191:0] cell_used;
  logic [7:0]    boundary_cell;
  logic [7:0]    cell_now;
  logic [12:0]   rd_index;
  logic [7:0]    rd_cell;
  flash_state_s  q;
  flash_state_s  d;

  // a cell untouched since reset or erase reads erased, so the array needs no preset
  assign cell_now = cell_used[q.mem_addr[12:0]] ? array_mem[q.mem_addr[12:0]] : `ERASED_BYTE;
  assign rd_index = AVS_WRITEDATA[20:8];
  assign rd_cell  = cell_used[rd_index] ? array_mem[rd_index] : `ERASED_BYTE;

  // programming only clears bits, so a stray write never raises one
  always_ff @(posedge SYS_CLK) begin
    if (q.mem_wr) begin
      array_mem[q.mem_addr[12:0]] <= cell_now & q.mem_wdata; // see RULE25
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // whole erase: every cell drops to erased at once, the sweep only times the busy span
  // row erase not supported here
  logic        sweep_on;
  logic [12:0] sweep_addr;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sweep_on   <= 1'b0;
      sweep_addr <= 13'h0000;
      cell_used  <= '0;
    end else begin
      if (q.mem_erase) begin
        cell_used <= '0; // see RULE18
      end else if (q.mem_wr) begin
        cell_used[q.mem_addr[12:0]] <= 1'b1;
      end
      if (q.mem_erase && !sweep_on) begin
        sweep_on   <= 1'b1;
        sweep_addr <= 13'h0000;
      end else if (sweep_on) begin
        sweep_addr <= sweep_addr + 13'h0001;
        if (sweep_addr == 13'h1FFF) begin
          sweep_on <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protection decode
  logic [15:0] protect_start;
  wire  logic [7:0] start_mid;
  logic        addr_in_array;
  logic        row_protected;
  logic        all_open;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] wr_addr;
  logic [7:0]  wr_byte;
  logic [3:0]  ctl_req;

  assign boundary_cell = q.boundary;
  // one start-address bit per boundary bit
  generate
    for (genvar gi = 0; gi < 8; gi++) begin : g_start
      assign start_mid[gi] = boundary_cell[gi]; // see RULE19
    end
  endgenerate
  assign protect_start = {2'b11, start_mid, 6'b000000}; // see RULE19
  assign all_open      = (boundary_cell == `ERASED_BYTE) || PROTECTION_BYPASS_VOLTAGE; // see RULE17
  // all zeros start below the array, so everything is protected
  assign row_protected = !all_open && ({q.row, 5'b00000} >= protect_start ||
                         boundary_cell == 8'h00); // see RULE15
  assign bus_wr  = AVS_WRITE && q.waitreq;
  assign bus_rd  = AVS_READ && q.waitreq;
  assign wr_addr = AVS_WRITEDATA[23:8];
  assign wr_byte = AVS_WRITEDATA[7:0];
  assign ctl_req = AVS_WRITEDATA[3:0];
  assign addr_in_array = wr_addr >= `ARRAY_BASE;

  ////////////////////////////////////////////////////////////////////////////////
  // register window decode
  logic sel_control;
  logic sel_boundary;
  logic sel_status;
  logic sel_array;
  always_comb begin
    sel_control  = 1'b0;
    sel_boundary = 1'b0;
    sel_status   = 1'b0;
    sel_array    = 1'b0;
    if (AVS_ADDRESS == `OFS_CONTROL) begin
      sel_control = 1'b1;
    end else if (AVS_ADDRESS == `OFS_BOUNDARY) begin
      sel_boundary = 1'b1;
    end else if (AVS_ADDRESS == `OFS_STATUS) begin
      sel_status = 1'b1;
    end else if (AVS_ADDRESS == `OFS_ARRAY_DATA) begin
      sel_array = 1'b1;
    end
  end

  // select interlock: a write asking for both keeps program select only
  logic [3:0] ctl_masked;
  always_comb begin
    ctl_masked = ctl_req;
    if (ctl_req[`BIT_PROGRAM_SELECT] && ctl_req[`BIT_ERASE_SELECT]) begin
      ctl_masked[`BIT_ERASE_SELECT] = 1'b0; // see RULE23
    end
  end

  // every condition that must hold before the pump may start
  logic seq_ok;
  logic erase_whole;
  logic whole_open;
  logic hv_allowed;
  assign seq_ok      = q.op == OP_ARMED && q.checked;
  assign erase_whole = q.control[`BIT_ERASE_SELECT] && q.control[`BIT_WHOLE_ARRAY];
  assign whole_open  = boundary_cell == `ERASED_BYTE || PROTECTION_BYPASS_VOLTAGE; // see RULE4
  assign hv_allowed  = seq_ok && !row_protected && !q.row_mix &&
                       (q.control[`BIT_PROGRAM_SELECT] || q.control[`BIT_ERASE_SELECT]);

  // status word; a refusal stays internal and is never shown
  logic [31:0] status_word;
  always_comb begin
    status_word                    = 32'h00000000;
    status_word[`BIT_ST_RECOVERY]  = q.op == OP_RECOVER;
    status_word[`BIT_ST_PROTECTED] = row_protected;
    status_word[`BIT_ST_ROW_MIX]   = q.row_mix;
    status_word[`BIT_ST_ARMED]     = q.checked;
    status_word[`BIT_ST_STANDBY]   = q.standby;
  end

  // reads under high voltage, recovery or erase give the erased pattern
  logic [7:0] array_byte;
  always_comb begin
    array_byte = `ERASED_BYTE;
    if (q.op == OP_IDLE && !sweep_on) begin
      if (AVS_WRITEDATA[23:8] == `BOUNDARY_ADDR) begin
        array_byte = boundary_cell;
      end else begin
        array_byte = rd_cell; // see RULE3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d           = q;
    d.mem_wr    = 1'b0;
    d.mem_erase = 1'b0;
    // every access answers one cycle after it is seen
    d.waitreq   = !(AVS_READ || AVS_WRITE) || !q.waitreq;
    if (AVS_WRITE && !q.waitreq) begin
      d.waitreq = 1'b1;
    end
    d.mem_data = rd_cell;

    if (bus_wr && AVS_BYTEENABLE[0]) begin
      if (sel_control) begin
        d.control = ctl_masked; // see RULE27 RULE23
        d.control[`BIT_HIGH_VOLTAGE] = 1'b0;
        if (ctl_req[`BIT_HIGH_VOLTAGE]) begin
          if (q.control[`BIT_HIGH_VOLTAGE]) begin
            d.control[`BIT_HIGH_VOLTAGE] = 1'b1;
          end else if (hv_allowed) begin
            d.control[`BIT_HIGH_VOLTAGE] = 1'b1; // see RULE24 RULE14 RULE16
            d.op = OP_HIGH;
            if (erase_whole) begin
              if (whole_open) begin
                d.mem_erase = 1'b1; // see RULE4
                d.boundary  = `ERASED_BYTE; // see RULE18
              end else begin
                d.control[`BIT_HIGH_VOLTAGE] = 1'b0;
                d.op = OP_ARMED;
                d.refused = 1'b1; // see RULE26
              end
            end
          end else begin
            d.refused = 1'b1; // see RULE26
          end
        end
        // dropping both selects before the pump starts abandons the sequence
        if (!ctl_masked[`BIT_PROGRAM_SELECT] && !ctl_masked[`BIT_ERASE_SELECT] &&
            (q.op == OP_ARMED || q.op == OP_IDLE)) begin
          d.op = OP_IDLE;
          d.checked = 1'b0;
        end
        if (q.control[`BIT_HIGH_VOLTAGE] && !ctl_req[`BIT_HIGH_VOLTAGE]) begin
          d.op = OP_RECOVER;
          d.rcv_count = 5'(`READ_RECOVERY_CYC);
        end
      end else if (sel_array && addr_in_array) begin
        if (q.control[`BIT_PROGRAM_SELECT] || q.control[`BIT_ERASE_SELECT]) begin
          if (q.op == OP_IDLE) begin
            d.op  = OP_ARMED; // see RULE7
            d.row = wr_addr[15:5];
            d.row_mix = 1'b0;
          end else if (q.op == OP_HIGH && q.control[`BIT_PROGRAM_SELECT]) begin
            if (wr_addr[15:5] != q.row) begin
              d.row_mix = 1'b1; // see RULE5
            end else if (!row_protected) begin
              if (wr_addr == `BOUNDARY_ADDR) begin
                // once set, the boundary byte is locked unless bypassed
                if (all_open) begin
                  d.boundary = q.boundary & wr_byte; // see RULE16
                end
              end else begin
                d.mem_wr    = 1'b1;
                d.mem_addr  = wr_addr;
                d.mem_wdata = wr_byte;
              end
            end
          end
        end
      end
    end

    // the boundary read counts once a select bit is set, before or after the row write
    if (bus_rd && sel_boundary &&
        (q.control[`BIT_PROGRAM_SELECT] || q.control[`BIT_ERASE_SELECT]) &&
        (q.op == OP_IDLE || q.op == OP_ARMED)) begin
      d.checked = 1'b1; // see RULE13
    end
    if (bus_rd) begin
      d.rdata = 32'h00000000;
      if (sel_control) begin
        d.rdata[3:0] = q.control;
      end else if (sel_boundary) begin
        d.rdata[7:0] = boundary_cell;
      end else if (sel_status) begin
        d.rdata = status_word;
      end else if (sel_array) begin
        d.rdata[7:0] = array_byte;
      end
    end

    if (q.op == OP_RECOVER) begin
      if (q.rcv_count <= 5'h01) begin
        d.op = OP_IDLE; // see RULE3
        d.checked = 1'b0;
        d.row_mix = 1'b0;
      end else begin
        d.rcv_count = q.rcv_count - 5'h01;
      end
    end

    d.pump = d.control[`BIT_HIGH_VOLTAGE];
    if (LOW_POWER_ENTRY && q.op != OP_IDLE) begin
      d.control = `RESET_CONTROL; // see RULE21 RULE22
      d.op      = OP_IDLE;
      d.checked = 1'b0;
      d.pump    = 1'b0;
      d.mem_wr  = 1'b0;
      d.standby = 1'b1;
    end else if (q.op != OP_IDLE || d.op != OP_IDLE) begin
      d.standby = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      q          <= '0;
      q.control  <= `RESET_CONTROL;
      q.boundary <= `RESET_BOUNDARY;
      q.op       <= OP_IDLE;
      q.waitreq  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      // outputs come straight from flops so the bus answer is fixed at one cycle
      AVS_READDATA    <= 32'h00000000;
      AVS_WAITREQUEST <= 1'b1;
      HIGH_VOLTAGE_ON <= 1'b0;
      READ_READY      <= 1'b1;
    end else begin
      AVS_READDATA    <= d.rdata;
      AVS_WAITREQUEST <= d.waitreq;
      HIGH_VOLTAGE_ON <= d.pump;
      READ_READY      <= d.op == OP_IDLE;
    end
  end
endmodule : flash_erase_program_protect
`default_nettype wire

// File: verification/fepp_checker.sv
// port assertions of the array controller
`timescale 1ns/100ps
`default_nettype none
module fepp_checker (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        LOW_POWER_ENTRY,
  input wire logic        HIGH_VOLTAGE_ON,
  input wire logic        READ_READY
);
  logic cw;
  // control write acknowledged at this edge; the controller took it one edge earlier
  assign cw = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  ////////////////////
  property p_hv_set;
    $rose(HIGH_VOLTAGE_ON) |-> (cw && AVS_WRITEDATA[3]) || $past(cw && AVS_WRITEDATA[3]);
  endproperty
  a_hv_set: assert property (p_hv_set) else $error("hv rose unasked");
  property p_hv_clr;
    $fell(HIGH_VOLTAGE_ON) |-> cw || $past(cw || LOW_POWER_ENTRY);
  endproperty
  a_hv_clr: assert property (p_hv_clr) else $error("hv fell unasked");
  property p_stby;
    $rose(LOW_POWER_ENTRY) |-> ##[1:2] !HIGH_VOLTAGE_ON;
  endproperty
  a_stby: assert property (p_stby) else $error("hv kept in standby");
  property p_stby_hold;
    LOW_POWER_ENTRY [*3] |-> !HIGH_VOLTAGE_ON;
  endproperty
  a_stby_hold: assert property (p_stby_hold) else $error("hv on in standby");
  property p_busy;
    HIGH_VOLTAGE_ON |-> !READ_READY;
  endproperty
  a_busy: assert property (p_busy) else $error("readable under hv");
  // abort by low power is excluded: it skips recovery and goes straight to idle
  property p_rcv;
    $fell(HIGH_VOLTAGE_ON) && !LOW_POWER_ENTRY |-> !READ_READY [*8] ##[1:5] READ_READY;
  endproperty
  a_rcv: assert property (p_rcv) else $error("recovery length wrong");
  property p_lock;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0 |-> !(AVS_READDATA[0] && AVS_READDATA[1]);
  endproperty
  a_lock: assert property (p_lock) else $error("both selects set");
  property p_ans;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
endmodule : fepp_checker
bind flash_erase_program_protect fepp_checker fepp_checker_i (
  .SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .LOW_POWER_ENTRY(LOW_POWER_ENTRY),
  .HIGH_VOLTAGE_ON(HIGH_VOLTAGE_ON), .READ_READY(READ_READY));
`default_nettype wire

// File: verification/tb_flash_erase_program_protect.sv
// bench of the array controller over its register bus
`timescale 1ns/100ps
`default_nettype none
module tb_flash_erase_program_protect;
  logic        clk = 0, rst = 1, rs = 0, ws = 0, lp = 0, byp = 0;
  logic [3:0]  adr = 0;
  logic [31:0] wd = 0, rdt;
  logic        wrq, hv, rr;
  int          err_count = 0, num_checks = 0;
  flash_erase_program_protect flash_erase_program_protect_i (
    .SYS_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rs), .AVS_WRITE(ws),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdt), .AVS_WAITREQUEST(wrq),
    .LOW_POWER_ENTRY(lp), .PROTECTION_BYPASS_VOLTAGE(byp), .HIGH_VOLTAGE_ON(hv),
    .READ_READY(rr));
  initial forever #50 clk = ~clk;
  ////////////////////
  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // one edge first, so a released request never rises in the same step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wd <= d;
    ws <= w;
    rs <= !w;
    do @(posedge clk); while (wrq !== 1'b0);
    q = rdt;
    ws <= 1'b0;
    rs <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string n, input logic [3:0] a, input logic [15:0] p,
                    input logic [7:0] m, e);
    logic [31:0] q;
    bus(1'b0, a, {8'h00, p, 8'h00}, q);
    check(n, q[7:0] & m, e);
  endtask : rd
  // software owns all waits, so only the 14-cycle recovery wait before the last check is spent
  task automatic prog(input logic [15:0] r, a1, input logic [7:0] d1,
                      input logic [15:0] a2, input logic [7:0] d2, b, input logic h, x);
    wr(4'h0, 32'h1);
    rd("bnd", 4'h1, 16'h0, 8'hFF, b);
    wr(4'h4, {8'h00, r, 8'hFF});
    wr(4'h0, 32'h9);
    rd("ctl", 4'h0, 16'h0, 8'h0F, h ? 8'h09 : 8'h01);
    check("hv", hv, h);
    if (h) begin
      check("rr", rr, 1'b0);
      wr(4'h4, {8'h00, a1, d1});
      wr(4'h4, {8'h00, a2, d2});
      rd("mix", 4'h2, 16'h0, 8'h04, x ? 8'h04 : 8'h00);
      wr(4'h0, 32'h8);
    end
    wr(4'h0, 32'h0);
    repeat (14) @(posedge clk);
    check("rr", rr, 1'b1);
  endtask : prog
  ////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd("bnd", 4'h1, 16'h0, 8'hFF, 8'hFF);
    rd("nil", 4'hF, 16'h0, 8'hFF, 8'h00);
    wr(4'h0, 32'h3);
    rd("lck", 4'h0, 16'h0, 8'h0F, 8'h01);
    wr(4'h0, 32'h9);
    rd("seq", 4'h0, 16'h0, 8'h0F, 8'h01);
    wr(4'h0, 32'h0);
    prog(16'hE000, 16'hE000, 8'h5A, 16'hE01F, 8'h3C, 8'hFF, 1'b1, 1'b0);
    rd("pg", 4'h4, 16'hE01F, 8'hFF, 8'h3C);
    prog(16'hE040, 16'hE040, 8'h11, 16'hE060, 8'h22, 8'hFF, 1'b1, 1'b1);
    rd("row", 4'h4, 16'hE060, 8'hFF, 8'hFF);
    prog(16'hFF60, 16'hFF7E, 8'hFC, 16'hFF7F, 8'hFF, 8'hFF, 1'b1, 1'b0);
    prog(16'hFF00, 16'hFF00, 8'h00, 16'hFF01, 8'h00, 8'hFC, 1'b0, 1'b0);
    prog(16'hFEE0, 16'hFEE0, 8'h00, 16'hFEE1, 8'hFF, 8'hFC, 1'b1, 1'b0);
    wr(4'h0, 32'h6);
    rd("bnd", 4'h1, 16'h0, 8'hFF, 8'hFC);
    wr(4'h4, 32'hE000FF);
    wr(4'h0, 32'hE);
    rd("era", 4'h0, 16'h0, 8'h08, 8'h00);
    wr(4'h0, 32'h0);
    byp <= 1'b1;
    prog(16'hFF00, 16'hFF00, 8'h77, 16'hFF01, 8'hFF, 8'hFC, 1'b1, 1'b0);
    byp <= 1'b0;
    rd("byp", 4'h4, 16'hFF00, 8'hFF, 8'h77);
    byp <= 1'b1;
    wr(4'h0, 32'h6);
    rd("bnd", 4'h1, 16'h0, 8'hFF, 8'hFC);
    wr(4'h4, 32'hFF7EFF);
    wr(4'h0, 32'hE);
    rd("mer", 4'h0, 16'h0, 8'h0F, 8'h0E);
    wr(4'h0, 32'h8);
    wr(4'h0, 32'h0);
    byp <= 1'b0;
    repeat (14) @(posedge clk);
    rd("bnd", 4'h1, 16'h0, 8'hFF, 8'hFF);
    rd("ers", 4'h4, 16'hE01F, 8'hFF, 8'hFF);
    wr(4'h0, 32'h1);
    rd("bnd", 4'h1, 16'h0, 8'hFF, 8'hFF);
    wr(4'h4, 32'hE080FF);
    wr(4'h0, 32'h9);
    lp <= 1'b1;
    repeat (3) @(posedge clk);
    check("stb", hv, 1'b0);
    lp <= 1'b0;
    wr(4'h0, 32'h0);
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end
endmodule : tb_flash_erase_program_protect
`default_nettype wire
